// file: logic/gpcde_pkg.sv
/*
  package for the port c/d/e register block: offsets, reset values, types.
  assumes the core presents an i/o-space port and a data-space port.
*/
// What this block does
// - short i/o path decodes addresses 0x00-0x3f only
// - data space maps i/o offset plus 0x20
// - extended region from 0x60 not decoded; data-space reads there return zero
// - eight bits, bit n maps pin n
// - output latches read/write, reset to zero
// - direction registers read/write, reset to input
// - pin level registers read-only, follow pins
// - legacy mode: port c outputs driving zero
// - legacy port c state needs no clock
// - input with latch one gets pull-up unless disabled
package gpcde_pkg;
  localparam int gpcde_width = 8;
  localparam logic [5:0] gpcde_io_last = 6'h3f;
  localparam logic [7:0] gpcde_data_offset = 8'h20;
  localparam logic [7:0] gpcde_ext_base = 8'h60;
  localparam logic [5:0] gpcde_pad_e = 6'h01;
  localparam logic [5:0] gpcde_dir_e = 6'h02;
  localparam logic [5:0] gpcde_out_e = 6'h03;
  localparam logic [5:0] gpcde_pad_d = 6'h10;
  localparam logic [5:0] gpcde_dir_d = 6'h11;
  localparam logic [5:0] gpcde_out_d = 6'h12;
  localparam logic [5:0] gpcde_pad_c = 6'h13;
  localparam logic [5:0] gpcde_dir_c = 6'h14;
  localparam logic [5:0] gpcde_out_c = 6'h15;
  localparam logic [7:0] gpcde_dir_reset = 8'h00;
  localparam logic [7:0] gpcde_out_reset = 8'h00;
  localparam logic [7:0] gpcde_sync_reset = 8'h00;

  typedef struct packed {
    logic [7:0] pad_o;
    logic [7:0] oe_o;
    logic [7:0] pullup_o;
  } gpcde_pins_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpcde_req_type;
endpackage

// file: logic/gpcde_top.sv
/*
  port c, d, e registers with pin drive, enable and pull-up control.
  assumes the core issues one access per port per cycle; pin inputs are
  asynchronous and pass two flip-flops before being read.
*/
`timescale 1ns/1ps
module gpcde_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // mode straps
  input wire logic legacy_mode_i,
  input wire logic global_pullup_off_i,
  // short i/o access
  input wire gpcde_pkg::gpcde_req_type io_req_i,
  output logic [7:0] io_rdata_o,
  // data-space access
  input wire gpcde_pkg::gpcde_req_type mem_req_i,
  output logic [7:0] mem_rdata_o,
  // pins, index 0 = c, 1 = d, 2 = e
  input wire logic [7:0] pin_c_i,
  input wire logic [7:0] pin_d_i,
  input wire logic [7:0] pin_e_i,
  output gpcde_pkg::gpcde_pins_type port_c_o,
  output gpcde_pkg::gpcde_pins_type port_d_o,
  output gpcde_pkg::gpcde_pins_type port_e_o
);
  import gpcde_pkg::*;

  logic [7:0] dir_reg [3];
  logic [7:0] out_reg [3];
  logic [7:0] sync1_reg [3];
  logic [7:0] sync2_reg [3];
  logic [7:0] io_rdata_reg;
  logic [7:0] mem_rdata_reg;
  gpcde_pins_type pins_reg [3];
  logic [7:0] pin_in [3];
  logic [7:0] off_pad [3];
  logic [7:0] off_dir [3];
  logic [7:0] off_out [3];

  assign pin_in[0] = pin_c_i;
  assign pin_in[1] = pin_d_i;
  assign pin_in[2] = pin_e_i;
  assign off_pad[0] = {2'b00, gpcde_pad_c};
  assign off_pad[1] = {2'b00, gpcde_pad_d};
  assign off_pad[2] = {2'b00, gpcde_pad_e};
  assign off_dir[0] = {2'b00, gpcde_dir_c};
  assign off_dir[1] = {2'b00, gpcde_dir_d};
  assign off_dir[2] = {2'b00, gpcde_dir_e};
  assign off_out[0] = {2'b00, gpcde_out_c};
  assign off_out[1] = {2'b00, gpcde_out_d};
  assign off_out[2] = {2'b00, gpcde_out_e};

  // i/o path has 6 address bits; upper bits must be zero
  wire io_in_range = io_req_i.addr <= {2'b00, gpcde_io_last};
  // data space below 0x20 is core registers, 0x60 up is extended i/o
  wire mem_in_io = (mem_req_i.addr >= gpcde_data_offset) &&
                   (mem_req_i.addr < gpcde_ext_base);
  wire [7:0] mem_io_addr = mem_req_i.addr - gpcde_data_offset;
  wire io_wr = io_req_i.wr && io_in_range;
  wire io_rd = io_req_i.rd && io_in_range;
  wire mem_wr = mem_req_i.wr && mem_in_io;
  wire mem_rd = mem_req_i.rd && mem_in_io;

  logic [7:0] io_rsel [4];
  logic [7:0] mem_rsel [4];
  assign io_rsel[0] = 8'h00;
  assign mem_rsel[0] = 8'h00;

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      wire io_hit_dir = io_wr && (io_req_i.addr == off_dir[p]);
      wire io_hit_out = io_wr && (io_req_i.addr == off_out[p]);
      wire mem_hit_dir = mem_wr && (mem_io_addr == off_dir[p]);
      wire mem_hit_out = mem_wr && (mem_io_addr == off_out[p]);
      // data-space write wins if both paths hit the same register
      wire [7:0] dir_next = mem_hit_dir ? mem_req_i.wdata :
                            io_hit_dir ? io_req_i.wdata : dir_reg[p];
      wire [7:0] out_next = mem_hit_out ? mem_req_i.wdata :
                            io_hit_out ? io_req_i.wdata : out_reg[p];
      wire [7:0] io_val;
      wire [7:0] mem_val;
      wire [7:0] drive_en;
      wire [7:0] drive_val;

      // pad level read through the synchroniser output only
      assign io_val =
        (io_req_i.addr == off_pad[p]) ? sync2_reg[p] :
        (io_req_i.addr == off_dir[p]) ? dir_reg[p] :
        (io_req_i.addr == off_out[p]) ? out_reg[p] : 8'h00;
      assign mem_val =
        (mem_io_addr == off_pad[p]) ? sync2_reg[p] :
        (mem_io_addr == off_dir[p]) ? dir_reg[p] :
        (mem_io_addr == off_out[p]) ? out_reg[p] : 8'h00;
      assign io_rsel[p+1] = io_rsel[p] | io_val;
      assign mem_rsel[p+1] = mem_rsel[p] | mem_val;

      // legacy port c is forced to a driven-low output combinationally
      // from the strap, so no clock edge is needed to reach it
      if (p == 0) begin : g_legacy
        assign drive_en = legacy_mode_i ? 8'hff : dir_reg[p];
        assign drive_val = legacy_mode_i ? 8'h00 : out_reg[p];
      end else begin : g_plain
        assign drive_en = dir_reg[p];
        assign drive_val = out_reg[p];
      end

      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          dir_reg[p] <= gpcde_dir_reset;
          out_reg[p] <= gpcde_out_reset;
          sync1_reg[p] <= gpcde_sync_reset;
          sync2_reg[p] <= gpcde_sync_reset;
        end else begin
          dir_reg[p] <= dir_next;
          out_reg[p] <= out_next;
          sync1_reg[p] <= pin_in[p];
          sync2_reg[p] <= sync1_reg[p];
        end
      end

      // pin stage registered; reset clears it to zero, the legacy value is applied at the outputs
      always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          pins_reg[p] <= '0;
        end else begin
          pins_reg[p].oe_o <= drive_en;
          pins_reg[p].pad_o <= drive_val & drive_en;
          pins_reg[p].pullup_o <= ~drive_en & drive_val &
                                  {8{~global_pullup_off_i}};
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      io_rdata_reg <= 8'h00;
      mem_rdata_reg <= 8'h00;
    end else begin
      io_rdata_reg <= io_rd ? io_rsel[3] : 8'h00;
      mem_rdata_reg <= mem_rd ? mem_rsel[3] : 8'h00;
    end
  end

  // registered pin outputs lag a cycle; legacy override held at pins
  // combinationally so port c is low even before the first clock
  assign io_rdata_o = io_rdata_reg;
  assign mem_rdata_o = mem_rdata_reg;
  assign port_c_o.oe_o = legacy_mode_i ? 8'hff : pins_reg[0].oe_o;
  assign port_c_o.pad_o = legacy_mode_i ? 8'h00 : pins_reg[0].pad_o;
  assign port_c_o.pullup_o = legacy_mode_i ? 8'h00 : pins_reg[0].pullup_o;
  assign port_d_o = pins_reg[1];
  assign port_e_o = pins_reg[2];
endmodule

// file: test/gpcde_properties.sv
/* checker for the port c/d/e block, bound into gpcde_top.
   assumes the top's port names; watches top-level ports only. */
`timescale 1ns/1ps
module gpcde_properties (
  // clock and straps
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic legacy_mode_i,
  input wire logic global_pullup_off_i,
  // access and pins
  input wire gpcde_pkg::gpcde_req_type io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire gpcde_pkg::gpcde_req_type mem_req_i,
  input wire logic [7:0] mem_rdata_o,
  input wire logic [7:0] pin_c_i,
  input wire gpcde_pkg::gpcde_pins_type port_c_o,
  input wire gpcde_pkg::gpcde_pins_type port_d_o,
  input wire gpcde_pkg::gpcde_pins_type port_e_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence pin_c_steady; $stable(pin_c_i) [*3]; endsequence
  sequence dir_d_write; io_req_i.wr && io_req_i.addr == 8'h11; endsequence
  legacy_drive_a: assert property (legacy_mode_i |->
    port_c_o.oe_o == 8'hff && port_c_o.pad_o == 8'h00) else $error("legacy");
  pullup_off_a: assert property (global_pullup_off_i &&
    $past(global_pullup_off_i) |-> port_e_o.pullup_o == 8'h00) else $error("pu");
  pullup_input_a: assert property (
    (port_e_o.pullup_o & port_e_o.oe_o) == 8'h00) else $error("pu on output");
  io_range_a: assert property (io_req_i.rd && io_req_i.addr > 8'h3f
    |=> io_rdata_o == 8'h00) else $error("io range");
  mem_low_a: assert property (mem_req_i.rd && mem_req_i.addr < 8'h20
    |=> mem_rdata_o == 8'h00) else $error("mem low");
  mem_ext_a: assert property (mem_req_i.rd && mem_req_i.addr >= 8'h60
    |=> mem_rdata_o == 8'h00) else $error("mem ext");
  pad_sample_a: assert property (pin_c_steady ##0 (io_req_i.rd &&
    io_req_i.addr == 8'h13) |=> io_rdata_o == $past(pin_c_i)) else $error("pad");
  dir_to_oe_a: assert property (dir_d_write |=> ##1
    port_d_o.oe_o == $past(io_req_i.wdata, 2)) else $error("oe");
endmodule
bind gpcde_top gpcde_properties u_props (.*);

// file: test/gpcde_pads.sv
/* board model for one port: external drive, pull-ups, floating lines.
   assumes the block's pin struct and clock. */
`timescale 1ns/1ps
module gpcde_pads (
  // clock
  input wire logic clk_i,
  // block side and board side
  input wire gpcde_pkg::gpcde_pins_type port_i,
  input wire logic [7:0] board_i,
  input wire logic rel_i,
  output logic [7:0] pin_o
);
  // released lines without pull-up toggle so a stale level never reads back
  logic [7:0] noise_reg = 8'h55;
  always_ff @(posedge clk_i) noise_reg <= ~noise_reg;
  assign pin_o = (port_i.oe_o & port_i.pad_o) |
    (~port_i.oe_o & (rel_i ? (port_i.pullup_o | noise_reg) : board_i));
endmodule

// file: test/tb_top.sv
/* self-checking bench for the port c/d/e block.
   assumes gpcde_top, the bound checker and the board model. */
`timescale 1ns/1ps
module tb_top;
  import gpcde_pkg::*;
  logic mclk = 0, reset_n = 0, legacy = 0, pu_off = 0, rel_e = 0;
  gpcde_req_type io_req = '0, mem_req = '0;
  logic [7:0] io_rd, mem_rd, pin_c, pin_d, pin_e;
  gpcde_pins_type port_c, port_d, port_e;
  int error_cnt = 0, checks_done = 0, cycles = 0;
  logic [7:0] regs [6] = '{8'h02, 8'h03, 8'h11, 8'h12, 8'h14, 8'h15};
  gpcde_top u_dut (.mclk_i(mclk), .reset_n_i(reset_n), .legacy_mode_i(legacy),
    .global_pullup_off_i(pu_off), .io_req_i(io_req), .io_rdata_o(io_rd),
    .mem_req_i(mem_req), .mem_rdata_o(mem_rd), .pin_c_i(pin_c),
    .pin_d_i(pin_d), .pin_e_i(pin_e), .port_c_o(port_c), .port_d_o(port_d),
    .port_e_o(port_e));
  gpcde_pads u_pc (.clk_i(mclk), .port_i(port_c), .board_i(8'h3c),
    .rel_i(1'b0), .pin_o(pin_c));
  gpcde_pads u_pd (.clk_i(mclk), .port_i(port_d), .board_i(8'ha9),
    .rel_i(1'b0), .pin_o(pin_d));
  gpcde_pads u_pe (.clk_i(mclk), .port_i(port_e), .board_i(8'h00),
    .rel_i(rel_e), .pin_o(pin_e));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input bit m, w, input logic [7:0] a, d);
    @(posedge mclk);
    if (m) mem_req <= '{w, !w, a, d};
    else io_req <= '{w, !w, a, d};
    @(posedge mclk);
    io_req <= '0;
    mem_req <= '0;
    #1;
  endtask
  task automatic rd(input bit m, input logic [7:0] a, exp);
    acc(m, 0, a, 8'h00);
    chk(m ? mem_rd : io_rd, exp);
    // read data stands one cycle only, then falls back to zero
    @(posedge mclk);
    #1 chk(m ? mem_rd : io_rd, 8'h00);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    foreach (regs[i]) rd(0, regs[i], 8'h00);
    $display("test reset values done");
    foreach (regs[i]) acc(0, 1, regs[i], regs[i] ^ 8'h5a);
    foreach (regs[i]) rd(1, regs[i] + 8'h20, regs[i] ^ 8'h5a);
    rd(0, 8'h10, (8'h4b & 8'h48) | (~8'h4b & 8'ha9));
    chk(port_d.pad_o, 8'h4b & 8'h48);
    chk(port_d.oe_o, 8'h4b);
    $display("test access paths done");
    rd(0, 8'h55, 8'h00);
    rd(1, 8'h10, 8'h00);
    rd(1, 8'h75, 8'h00);
    acc(0, 1, 8'h13, 8'hff);
    rd(0, 8'h13, (8'h4e & 8'h4f) | (~8'h4e & 8'h3c));
    $display("test refusals done");
    acc(0, 1, 8'h02, 8'h00);
    acc(1, 1, 8'h23, 8'hff);
    rel_e <= 1;
    repeat (4) @(posedge mclk);
    rd(0, 8'h01, 8'hff);
    chk(port_e.pullup_o, 8'hff);
    @(posedge mclk) pu_off <= 1;
    repeat (3) @(posedge mclk);
    #1 chk(port_e.pullup_o, 8'h00);
    $display("test pull-ups done");
    // no access to the port c direction while in legacy mode
    @(posedge mclk) legacy <= 1;
    #1 chk(port_c.oe_o, 8'hff);
    chk(port_c.pad_o, 8'h00);
    chk(port_c.pullup_o, 8'h00);
    $display("test legacy done");
    end_of_test();
  end
endmodule
